// [hw/bcx_core.sv]
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Rotate right through carry: carry into bit 7, bit 0 into carry, 4 states.
// - Invert accumulator: every bit flipped, flags untouched, 4 states.
// - Toggle carry: carry inverted, no other flag, 4 states.
// - Set carry: carry forced to one, no other flag, 4 states.
// - Branch group never changes any condition flag.
// - Condition field picks zero, carry, parity or sign, clear or set.
// - Jumps load address bytes 3:2; failed test falls through; 10 states.
// - Call pushes high then low return byte, SP minus 2, 17 states.
// - Conditional call: full call if true, else 11 states.
// - Return pops low then high byte, SP plus 2, 10 states.
// - Conditional return: 5 states if not taken, 11 if taken.
// - Restart pushes like call, jumps to eight times index, 11 states.
// - Indirect jump copies H and L into the counter, 5 states.
// - Status byte: S,Z,0,AC,0,P,1,CY from bit 7 down.
// - Push pair: high at SP-1, low at SP-2, SP minus 2, 11 states.
// - Pop pair: low from SP, high from SP+1, SP plus 2, 10 states.
// - Status word push and pop carry the accumulator and flag byte.
// - Stack top swap exchanges L and H with memory, SP kept, 18 states.
// - Load stack from H and L, 5 states.
// - Enable interrupts takes effect after the next instruction ends.
// - Block interrupts takes effect as soon as it ends.
// - Input reads the port byte from the data bus into A, 10 states.
// - Halt stops execution, registers and flags kept.
module bcx_core
  import bcx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  data_i,
  output bcx_bus_t         bus_o,
  output logic             int_enable_o,
  output logic             halted_o
);

  bcx_state_t  s_q;
  bcx_state_t  s_d;
  bcx_cls_t    cls;
  logic        taken;
  logic        ext;
  logic        last;
  logic        done;
  logic        wr_ok;
  logic [7:0]  rdat;
  logic [7:0]  status_word;
  logic [7:0]  pair_hi;
  logic [7:0]  pair_lo;

  function automatic bcx_cls_t cls_of(input logic [7:0] op);
    bcx_cls_t k;
    k = CL_NOP;
    if (op == OP_ROTATE_RIGHT_THROUGH_CARRY) k = CL_ROT;
    else if (op == OP_INVERT_ACCUMULATOR) k = CL_INV;
    else if (op == OP_TOGGLE_CARRY) k = CL_TGL;
    else if (op == OP_SET_CARRY) k = CL_SETC;
    else if (op == OP_JUMP_DIRECT) k = CL_JMP;
    else if (op == OP_CALL) k = CL_CALL;
    else if (op == OP_SUBROUTINE_RETURN) k = CL_RET;
    else if (op == OP_JUMP_INDIRECT_PAIR) k = CL_JUMP_INDIRECT_PAIR;
    else if (op == OP_LOAD_STACK_FROM_PAIR) k = CL_LOAD_STACK_FROM_PAIR;
    else if ((op & MASK_CCC) == PAT_JUMP_COND) k = CL_JCC;
    else if ((op & MASK_CCC) == PAT_CALL_COND) k = CL_CCC;
    else if ((op & MASK_CCC) == PAT_RETURN_COND) k = CL_RCC;
    else if ((op & MASK_CCC) == PAT_RESTART) k = CL_RST;
    else if ((op & MASK_PAIR) == PAT_PUSH) k = CL_PUSH;
    else if ((op & MASK_PAIR) == PAT_POP) k = CL_POP;
    return k;
  endfunction

  function automatic bcx_state_t issue(input bcx_state_t s,
                                       input bcx_kind_t  k,
                                       input logic [15:0] adr,
                                       input logic [7:0]  dv,
                                       input logic [2:0]  n);
    bcx_state_t r;
    r = s;
    r.t = 3'h0;
    r.len = n;
    r.bus.addr = adr;
    r.bus.dout = dv;
    r.bus.oe = (k == K_MEM_WR);
    r.bus.wr = (k == K_MEM_WR);
    r.bus.rd = (k == K_MEM_RD) || (k == K_IO_RD);
    r.bus.io = (k == K_IO_RD);
    return r;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dv,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = dv[7:0];
    if (sel[1]) r[15:8] = dv[15:8];
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    done = 1'b0;
    wr_ok = (s_q.ph != PH_RUN) && !s_q.run;
    s_d.sy1 = data_i;
    s_d.sy2 = s_q.sy1;
    rdat = s_q.sy2;
    cls = cls_of(s_q.op);
    status_word = (s_q.f & FLAG_KEEP) | FLAG_ONES;
    case (s_q.op[5:3])
      3'h0: taken = !s_q.f[FLAG_Z];
      3'h1: taken = s_q.f[FLAG_Z];
      3'h2: taken = !s_q.f[FLAG_CY];
      3'h3: taken = s_q.f[FLAG_CY];
      3'h4: taken = !s_q.f[FLAG_P];
      3'h5: taken = s_q.f[FLAG_P];
      3'h6: taken = !s_q.f[FLAG_S];
      default: taken = s_q.f[FLAG_S];
    endcase
    case (s_q.op[5:4])
      2'h0: begin pair_hi = s_q.b; pair_lo = s_q.c; end
      2'h1: begin pair_hi = s_q.d; pair_lo = s_q.e; end
      2'h2: begin pair_hi = s_q.h; pair_lo = s_q.l; end
      default: begin pair_hi = s_q.a; pair_lo = status_word; end
    endcase
    // Opcode fetch runs one state longer for these classes
    ext = (s_q.mc == 3'h0) && (s_q.t == 3'h3) && (s_q.len == T_FETCH) &&
          (cls == CL_CALL || cls == CL_CCC || cls == CL_RCC ||
           cls == CL_RST || cls == CL_JUMP_INDIRECT_PAIR || cls == CL_LOAD_STACK_FROM_PAIR ||
           cls == CL_PUSH);
    last = (s_q.t == s_q.len - 3'h1) && !ext;

    case (s_q.ph)
      PH_IDLE: begin
        if (s_q.run) begin
          s_d.ph = PH_RUN;
          s_d.mc = 3'h0;
          s_d = issue(s_d, K_MEM_RD, s_q.pc, 8'h00, T_FETCH);
        end
      end
      PH_HALT: begin
        s_d.bus.rd = 1'b0;
      end
      PH_RUN: begin
        s_d.t = s_q.t + 3'h1;
        if (ext) s_d.len = T_FETCH_LONG;
        // Strobes drop in the last state so each cycle has an edge
        if (s_q.t == s_q.len - 3'h2) begin
          s_d.bus.rd = 1'b0;
          s_d.bus.wr = 1'b0;
        end
        if (s_q.mc == 3'h0 && s_q.t == 3'h2) begin
          s_d.op = rdat;
          s_d.pc = s_q.pc + 16'h0001;
          s_d.swap_stack_top_pair = (rdat == OP_SWAP_STACK_TOP_PAIR);
          s_d.ei = (rdat == OP_ENABLE_INTERRUPTS);
          s_d.di = (rdat == OP_BLOCK_INTERRUPTS);
          s_d.inp = (rdat == OP_INPUT);
          s_d.halt_op = (rdat == OP_HALT_OP);
        end
        if (last) begin
          case (s_q.mc)
            3'h0: begin
              done = !(s_q.swap_stack_top_pair || s_q.inp || cls == CL_JMP ||
                       cls == CL_JCC || cls == CL_CALL || cls == CL_CCC ||
                       cls == CL_RET || cls == CL_RST || cls == CL_PUSH ||
                       cls == CL_POP || (cls == CL_RCC && taken));
              case (cls)
                CL_ROT: begin
                  s_d.a = {s_q.f[FLAG_CY], s_q.a[7:1]};
                  s_d.f[FLAG_CY] = s_q.a[0];
                end
                CL_INV: s_d.a = ~s_q.a;
                CL_TGL: s_d.f[FLAG_CY] = ~s_q.f[FLAG_CY];
                CL_SETC: s_d.f[FLAG_CY] = 1'b1;
                CL_JUMP_INDIRECT_PAIR: s_d.pc = {s_q.h, s_q.l};
                CL_LOAD_STACK_FROM_PAIR: s_d.sp = {s_q.h, s_q.l};
                CL_RST: s_d.tmp = {10'h000, s_q.op[5:3], 3'h0};
                default: ;
              endcase
            end
            3'h1: begin
              if (cls == CL_JMP || cls == CL_JCC || cls == CL_CALL ||
                  cls == CL_CCC || s_q.inp) begin
                s_d.tmp[7:0] = rdat;
                s_d.pc = s_q.pc + 16'h0001;
              end else if (cls == CL_RET || cls == CL_RCC ||
                           cls == CL_POP || s_q.swap_stack_top_pair) begin
                s_d.tmp[7:0] = rdat;
              end
            end
            3'h2: begin
              done = 1'b1;
              case (cls)
                CL_JMP, CL_JCC: begin
                  s_d.pc = (taken || cls == CL_JMP) ?
                           {rdat, s_q.tmp[7:0]} : s_q.pc + 16'h0001;
                end
                CL_CALL, CL_CCC: begin
                  s_d.pc = s_q.pc + 16'h0001;
                  s_d.tmp[15:8] = rdat;
                  done = (cls == CL_CCC) && !taken;
                end
                CL_RET, CL_RCC: begin
                  s_d.pc = {rdat, s_q.tmp[7:0]};
                  s_d.sp = s_q.sp + 16'h0002;
                end
                CL_POP: begin
                  s_d.sp = s_q.sp + 16'h0002;
                  case (s_q.op[5:4])
                    2'h0: begin s_d.b = rdat; s_d.c = s_q.tmp[7:0]; end
                    2'h1: begin s_d.d = rdat; s_d.e = s_q.tmp[7:0]; end
                    2'h2: begin s_d.h = rdat; s_d.l = s_q.tmp[7:0]; end
                    default: begin
                      s_d.a = rdat;
                      s_d.f = (s_q.tmp[7:0] & FLAG_KEEP) | FLAG_ONES;
                    end
                  endcase
                end
                CL_RST: begin
                  s_d.pc = s_q.tmp;
                  s_d.sp = s_q.sp - 16'h0002;
                end
                CL_PUSH: s_d.sp = s_q.sp - 16'h0002;
                default: begin
                  if (s_q.inp) s_d.a = rdat;
                  if (s_q.swap_stack_top_pair) begin
                    s_d.tmp[15:8] = rdat;
                    done = 1'b0;
                  end
                end
              endcase
            end
            3'h4: begin
              done = 1'b1;
              if (s_q.swap_stack_top_pair) begin
                s_d.l = s_q.tmp[7:0];
                s_d.h = s_q.tmp[15:8];
              end else begin
                s_d.sp = s_q.sp - 16'h0002;
                s_d.pc = s_q.tmp;
              end
            end
            default: ;
          endcase

          if (done) begin
            if (s_q.ei_pend) begin
              s_d.inte = 1'b1;
              s_d.ei_pend = 1'b0;
            end
            if (s_q.ei) s_d.ei_pend = 1'b1;
            if (s_q.di) begin
              s_d.inte = 1'b0;
              s_d.ei_pend = 1'b0;
            end
            s_d.mc = 3'h0;
            if (s_q.halt_op) begin
              s_d.ph = PH_HALT;
              s_d = issue(s_d, K_NONE, s_q.bus.addr, 8'h00, T_FETCH);
            end else if (!s_q.run) begin
              s_d.ph = PH_IDLE;
              s_d = issue(s_d, K_NONE, s_q.bus.addr, 8'h00, T_FETCH);
            end else begin
              s_d = issue(s_d, K_MEM_RD, s_d.pc, 8'h00, T_FETCH);
            end
          end else begin
            s_d.mc = s_q.mc + 3'h1;
            case (s_d.mc)
              3'h1: begin
                if (cls == CL_RST) s_d = issue(s_d, K_MEM_WR,
                  s_d.sp - 16'h0001, s_d.pc[15:8], T_MEM);
                else if (cls == CL_PUSH) s_d = issue(s_d, K_MEM_WR,
                  s_d.sp - 16'h0001, pair_hi, T_MEM);
                else if (cls == CL_RET || cls == CL_RCC ||
                         cls == CL_POP || s_q.swap_stack_top_pair)
                  s_d = issue(s_d, K_MEM_RD, s_d.sp, 8'h00, T_MEM);
                else s_d = issue(s_d, K_MEM_RD, s_d.pc, 8'h00, T_MEM);
              end
              3'h2: begin
                if (cls == CL_RST) s_d = issue(s_d, K_MEM_WR,
                  s_d.sp - 16'h0002, s_d.pc[7:0], T_MEM);
                else if (cls == CL_PUSH) s_d = issue(s_d, K_MEM_WR,
                  s_d.sp - 16'h0002, pair_lo, T_MEM);
                else if (s_q.inp) s_d = issue(s_d, K_IO_RD,
                  {s_d.tmp[7:0], s_d.tmp[7:0]}, 8'h00, T_MEM);
                else if (cls == CL_RET || cls == CL_RCC ||
                         cls == CL_POP || s_q.swap_stack_top_pair)
                  s_d = issue(s_d, K_MEM_RD, s_d.sp + 16'h0001, 8'h00, T_MEM);
                else s_d = issue(s_d, K_MEM_RD, s_d.pc, 8'h00, T_MEM);
              end
              3'h3: begin
                if (s_q.swap_stack_top_pair) s_d = issue(s_d, K_MEM_WR,
                  s_d.sp + 16'h0001, s_q.h, T_MEM);
                else s_d = issue(s_d, K_MEM_WR,
                  s_d.sp - 16'h0001, s_d.pc[15:8], T_MEM);
              end
              default: begin
                if (s_q.swap_stack_top_pair) s_d = issue(s_d, K_MEM_WR,
                  s_d.sp, s_q.l, T_SWAP_LAST);
                else s_d = issue(s_d, K_MEM_WR,
                  s_d.sp - 16'h0002, s_d.pc[7:0], T_MEM);
              end
            endcase
          end
        end
      end
      default: s_d.ph = PH_IDLE;
    endcase

    // Register slave; core registers are writable only while stopped
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.dat = 32'h0000_0000;
    if (s_d.ack) begin
      case (wb_adr_i)
        REG_CTRL: begin
          s_d.dat[CTRL_RUN] = s_q.run;
          if (wb_we_i && wb_sel_i[0]) begin
            s_d.run = wb_dat_i[CTRL_RUN];
            if (s_q.ph == PH_HALT) s_d.ph = PH_IDLE;
          end
        end
        REG_STATUS: begin
          s_d.dat[STAT_HALTED] = (s_q.ph == PH_HALT);
          s_d.dat[STAT_IDLE] = (s_q.ph == PH_IDLE);
          s_d.dat[STAT_INTE] = s_q.inte;
          s_d.dat[STAT_EIPEND] = s_q.ei_pend;
        end
        REG_PC: begin
          s_d.dat[15:0] = s_q.pc;
          if (wb_we_i && wr_ok) s_d.pc = merge16(s_q.pc, wb_dat_i, wb_sel_i);
        end
        REG_SP: begin
          s_d.dat[15:0] = s_q.sp;
          if (wb_we_i && wr_ok) s_d.sp = merge16(s_q.sp, wb_dat_i, wb_sel_i);
        end
        REG_AF: begin
          s_d.dat[15:0] = {s_q.a, status_word};
          if (wb_we_i && wr_ok) begin
            {s_d.a, s_d.f} = merge16({s_q.a, status_word}, wb_dat_i, wb_sel_i);
            s_d.f = (s_d.f & FLAG_KEEP) | FLAG_ONES;
          end
        end
        REG_BC: begin
          s_d.dat[15:0] = {s_q.b, s_q.c};
          if (wb_we_i && wr_ok)
            {s_d.b, s_d.c} = merge16({s_q.b, s_q.c}, wb_dat_i, wb_sel_i);
        end
        REG_DE: begin
          s_d.dat[15:0] = {s_q.d, s_q.e};
          if (wb_we_i && wr_ok)
            {s_d.d, s_d.e} = merge16({s_q.d, s_q.e}, wb_dat_i, wb_sel_i);
        end
        REG_HL: begin
          s_d.dat[15:0] = {s_q.h, s_q.l};
          if (wb_we_i && wr_ok)
            {s_d.h, s_d.l} = merge16({s_q.h, s_q.l}, wb_dat_i, wb_sel_i);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign bus_o = s_q.bus;
  assign int_enable_o = s_q.inte;
  // Halt is the only phase code with bit 1 set, so this is a plain flop
  assign halted_o = s_q.ph[1];

endmodule

// [hw/bcx_pkg.sv]
package bcx_pkg;

  // Opcodes and opcode patterns of the decoded group
  localparam logic [7:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 8'h1F;
  localparam logic [7:0] OP_INVERT_ACCUMULATOR         = 8'h2F;
  localparam logic [7:0] OP_TOGGLE_CARRY               = 8'h3F;
  localparam logic [7:0] OP_SET_CARRY                  = 8'h37;
  localparam logic [7:0] OP_JUMP_DIRECT                = 8'hC3;
  localparam logic [7:0] OP_CALL                       = 8'hCD;
  localparam logic [7:0] OP_SUBROUTINE_RETURN          = 8'hC9;
  localparam logic [7:0] OP_JUMP_INDIRECT_PAIR         = 8'hE9;
  localparam logic [7:0] OP_LOAD_STACK_FROM_PAIR       = 8'hF9;
  localparam logic [7:0] OP_SWAP_STACK_TOP_PAIR        = 8'hE3;
  localparam logic [7:0] OP_ENABLE_INTERRUPTS          = 8'hFB;
  localparam logic [7:0] OP_BLOCK_INTERRUPTS           = 8'hF3;
  localparam logic [7:0] OP_INPUT                      = 8'hDB;
  localparam logic [7:0] OP_HALT_OP                    = 8'h76;
  localparam logic [7:0] MASK_CCC                      = 8'hC7;
  localparam logic [7:0] MASK_PAIR                     = 8'hCF;
  localparam logic [7:0] PAT_JUMP_COND                 = 8'hC2;
  localparam logic [7:0] PAT_CALL_COND                 = 8'hC4;
  localparam logic [7:0] PAT_RETURN_COND               = 8'hC0;
  localparam logic [7:0] PAT_RESTART                   = 8'hC7;
  localparam logic [7:0] PAT_PUSH                      = 8'hC5;
  localparam logic [7:0] PAT_POP                       = 8'hC1;

  // Machine cycle lengths in clock states
  localparam logic [2:0] T_FETCH      = 3'h4;
  localparam logic [2:0] T_FETCH_LONG = 3'h5;
  localparam logic [2:0] T_MEM        = 3'h3;
  localparam logic [2:0] T_SWAP_LAST  = 3'h5;

  // Status byte layout
  localparam int unsigned FLAG_S  = 7;
  localparam int unsigned FLAG_Z  = 6;
  localparam int unsigned FLAG_AC = 4;
  localparam int unsigned FLAG_P  = 2;
  localparam int unsigned FLAG_CY = 0;
  localparam logic [7:0] FLAG_KEEP = 8'hD5;
  localparam logic [7:0] FLAG_ONES = 8'h02;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC     = 8'h08;
  localparam logic [7:0] REG_SP     = 8'h0C;
  localparam logic [7:0] REG_AF     = 8'h10;
  localparam logic [7:0] REG_BC     = 8'h14;
  localparam logic [7:0] REG_DE     = 8'h18;
  localparam logic [7:0] REG_HL     = 8'h1C;
  localparam int unsigned CTRL_RUN    = 0;
  localparam int unsigned STAT_HALTED = 0;
  localparam int unsigned STAT_IDLE   = 1;
  localparam int unsigned STAT_INTE   = 2;
  localparam int unsigned STAT_EIPEND = 3;

  typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_HALT} bcx_phase_t;
  typedef enum logic [1:0] {K_NONE, K_MEM_RD, K_MEM_WR, K_IO_RD} bcx_kind_t;
  typedef enum logic [3:0] {
    CL_NOP, CL_ROT, CL_INV, CL_TGL, CL_SETC, CL_JMP, CL_JCC, CL_CALL,
    CL_CCC, CL_RET, CL_RCC, CL_RST, CL_JUMP_INDIRECT_PAIR, CL_LOAD_STACK_FROM_PAIR, CL_PUSH, CL_POP
  } bcx_cls_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        oe;
    logic        rd;
    logic        wr;
    logic        io;
  } bcx_bus_t;

  typedef struct packed {
    bcx_phase_t  ph;
    logic [2:0]  mc;
    logic [2:0]  t;
    logic [2:0]  len;
    logic [7:0]  op;
    logic        swap_stack_top_pair;
    logic        ei;
    logic        di;
    logic        inp;
    logic        halt_op;
    logic [7:0]  a;
    logic [7:0]  f;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [7:0]  h;
    logic [7:0]  l;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] tmp;
    logic        inte;
    logic        ei_pend;
    logic        run;
    bcx_bus_t    bus;
    logic [7:0]  sy1;
    logic [7:0]  sy2;
    logic        ack;
    logic [31:0] dat;
  } bcx_state_t;

endpackage

// [testbench/bcx_chk.sv]
`timescale 1ns/1ps
module bcx_chk
  import bcx_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     rst,
  input wire logic     wb_cyc_i,
  input wire logic     wb_stb_i,
  input wire logic     wb_ack_o,
  input wire bcx_bus_t bus_o,
  input wire logic     halted_o
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_strobe_excl;
    !(bus_o.rd && bus_o.wr);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("rd and wr");
  property p_rd_float;
    bus_o.rd |-> !bus_o.oe && !bus_o.wr;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("drive in read");
  property p_rd_hold;
    $rose(bus_o.rd) |-> bus_o.rd [*2];
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read too short");
  property p_rd_addr;
    bus_o.rd && $past(bus_o.rd) |-> $stable(bus_o.addr);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("addr moved");
  property p_wr_hold;
    $rose(bus_o.wr) |=> bus_o.wr && bus_o.oe && $stable(bus_o.dout)
      && $stable(bus_o.addr);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write unstable");
  property p_halt_quiet;
    halted_o |-> !bus_o.rd && !bus_o.wr;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("bus in halt");
  property p_halt_hold;
    halted_o && !wb_cyc_i |=> halted_o;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left");

  c_halt_exit: cover property (halted_o ##1 !halted_o);
  c_write: cover property ($rose(bus_o.wr));
  c_port: cover property (bus_o.io && bus_o.rd);
endmodule

bind bcx_core bcx_chk chk_i (.core_clk(core_clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .bus_o(bus_o), .halted_o(halted_o));

// [testbench/bcx_mem.sv]
`timescale 1ns/1ps
module bcx_mem
  import bcx_pkg::*;
#(
  parameter logic [7:0] PORT_N = 8'h55
)
(
  input  wire logic       core_clk,
  input  wire bcx_bus_t   bus_i,
  input  wire logic [7:0] port_val,
  output logic      [7:0] data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  logic [7:0] rd_val;

  // Wrong port address answers garbage, so a bad pairing shows
  assign rd_val = !bus_i.io ? mem[bus_i.addr] :
                  (bus_i.addr == {PORT_N, PORT_N}) ? port_val : ~port_val;
  // Released bus must not look like a held byte
  assign data_o = bus_i.rd ? rd_val : ~last_q;

  always @(posedge core_clk) begin
    if (bus_i.rd) last_q <= rd_val;
    if (bus_i.wr && !bus_i.io) mem[bus_i.addr] <= bus_i.dout;
  end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
  import bcx_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        int_enable_o, halted_o, ie_seen;
  logic [7:0]  wb_adr_i, data_i, port_val, f;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, seed;
  logic [15:0] bc_val;
  logic [2:0]  cc;
  logic [63:0] note;
  bcx_bus_t    bus_o;
  logic [63:0] exp_q [$];
  logic [7:0]  mtab [6] = '{8'h7F, 8'h03, 8'h12, 8'h34, 8'h00, 8'h33};
  int unsigned fb [4] = '{FLAG_Z, FLAG_CY, FLAG_P, FLAG_S};
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;

  always #25 core_clk = ~core_clk;

  bcx_core dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .data_i(data_i), .bus_o(bus_o),
    .int_enable_o(int_enable_o), .halted_o(halted_o));
  bcx_mem mem_i (.core_clk(core_clk), .bus_i(bus_o), .port_val(port_val),
    .data_o(data_i));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Reads leave their expectation for the watcher below
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] m);
    if (!we) exp_q.push_back({d & m, m});
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(negedge core_clk); while (wb_ack_o !== 1'b1);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge core_clk);
  endtask

  task automatic poke(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) mem_i.mem[a + 16'(i)] = b[i];
  endtask

  task automatic run_to_halt();
    wb(1'b1, REG_CTRL, 32'h1, 32'h0);
    while (halted_o !== 1'b1) @(posedge core_clk);
  endtask

  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      note = exp_q.pop_front();
      check(wb_dat_o & note[31:0], note[63:32]);
    end
  end

  // Enable must wait until the restart after it has pushed its return
  always @(negedge core_clk) begin
    cycles++;
    if (int_enable_o === 1'b1 && !ie_seen) begin
      ie_seen = 1'b1;
      check(32'(mem_i.mem[16'h00FA]), 32'h33);
    end
    if (cycles > 6000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    ie_seen = 1'b0;
    seed = xs(32'h0000E55F);
    port_val = seed[7:0];
    bc_val = seed[23:8];
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, REG_AF, 32'h0002, 32'hFFFF);
    wb(1'b1, REG_AF, 32'h00FF, 32'h0);
    wb(1'b0, REG_AF, 32'h00D7, 32'hFFFF);
    wb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, REG_AF, 32'h0002, 32'h0);
    wb(1'b1, REG_SP, 32'h0100, 32'h0);
    wb(1'b1, REG_HL, 32'h1234, 32'h0);
    wb(1'b1, REG_BC, {16'h0, bc_val}, 32'h0);
    wb(1'b1, REG_PC, 32'h0, 32'h0);
    poke(16'h0000, '{8'h37, 8'h1F, 8'h2F, 8'h3F, 8'hF5, 8'hE5, 8'hD1, 8'hCD,
      8'h20, 8'h00, 8'hD2, 8'h40, 8'h00, 8'hD0, 8'hDA, 8'h30, 8'h00});
    poke(16'h0020, '{8'hDB, 8'h55, 8'hE3, 8'hE9});
    poke(16'h0028, '{8'hC9});
    poke(16'h0030, '{8'hF3, 8'hFB, 8'hEF, 8'hF9, 8'h76});
    run_to_halt();
    wb(1'b0, REG_AF, {16'h0, port_val, 8'h03}, 32'hFFFF);
    wb(1'b0, REG_BC, {16'h0, bc_val}, 32'hFFFF);
    wb(1'b0, REG_DE, 32'h1234, 32'hFFFF);
    wb(1'b0, REG_HL, 32'h000A, 32'hFFFF);
    wb(1'b0, REG_SP, 32'h000A, 32'hFFFF);
    wb(1'b0, REG_PC, 32'h0035, 32'hFFFF);
    wb(1'b0, REG_STATUS, 32'h5, 32'h5);
    for (int i = 0; i < 6; i++) begin
      check(32'(mem_i.mem[16'h00FF - 16'(i)]), 32'(mtab[i]));
    end
    poke(16'h00FF, '{8'hF3, 8'hC2, 8'h01, 8'h02, 8'h76});
    poke(16'h0201, '{8'h76});
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      cc = i[2:0];
      f = (seed[7:0] & FLAG_KEEP) | FLAG_ONES;
      f[fb[cc[2:1]]] = i[3];
      wb(1'b1, REG_CTRL, 32'h0, 32'h0);
      mem_i.mem[16'h0100] = PAT_JUMP_COND | {2'b00, cc, 3'b000};
      wb(1'b1, REG_PC, 32'h00FF, 32'h0);
      wb(1'b1, REG_AF, {16'h0, port_val, f}, 32'h0);
      run_to_halt();
      wb(1'b0, REG_PC, (f[fb[cc[2:1]]] == cc[0]) ? 32'h0202 : 32'h0104,
         32'hFFFF);
      wb(1'b0, REG_AF, {16'h0, port_val, f}, 32'hFFFF);
    end
    wb(1'b0, REG_STATUS, 32'h1, 32'h5);
    stop_test();
  end
endmodule
